//--- design/tap_pkg.sv
// constants for the boundary-scan test access port
package tap_pkg;
    localparam int IR_W      = 5;
    localparam int ID_W      = 32;
    localparam int BSR_CELLS = 8;             // pads in the scan chain
    localparam int CELL_W    = 3;             // input, output, enable bits
    localparam int CELL_IN   = 0;
    localparam int CELL_OUT  = 1;
    localparam int CELL_OE   = 2;
    localparam int BSR_W     = BSR_CELLS * CELL_W;
    localparam int CFG_W     = 8;             // configuration bus byte
    localparam int CFG_DEPTH = 8;             // load buffer words
    localparam int CNT_W     = 3;
    localparam logic [CNT_W-1:0] CNT_LAST = 3'h7;
    localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;

    localparam logic [IR_W-1:0] OP_EXTEST  = 5'h00;
    localparam logic [IR_W-1:0] OP_SAMPLE  = 5'h01;
    localparam logic [IR_W-1:0] OP_USER1   = 5'h02;
    localparam logic [IR_W-1:0] OP_USER2   = 5'h03;
    localparam logic [IR_W-1:0] OP_CFG_RD  = 5'h04;
    localparam logic [IR_W-1:0] OP_CFG_WR  = 5'h05;
    localparam logic [IR_W-1:0] OP_INTEST  = 5'h07;
    localparam logic [IR_W-1:0] OP_USERID  = 5'h08;
    localparam logic [IR_W-1:0] OP_IDCODE  = 5'h09;
    localparam logic [IR_W-1:0] OP_FLOAT   = 5'h0A;
    localparam logic [IR_W-1:0] OP_STARTUP = 5'h0C;
    localparam logic [IR_W-1:0] OP_BYPASS  = 5'h1F;
    localparam logic [IR_W-1:0] IR_CAPTURE = 5'h01;  // fixed 01 pattern

    typedef enum logic [3:0] {
        ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR,
        ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR,
        ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
    } tap_state_t;
endpackage

//--- design/boundary_scan_test_port.sv
// boundary-scan test access port with configuration load buffer
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// load buffer
// ****************************************************************
module cfg_fifo #(parameter int WIDTH = 8, parameter int DEPTH = 8) (
    input  wire logic             clk,       // system clock
    input  wire logic             rst,       // synchronous reset
    input  wire logic [WIDTH-1:0] in_data,   // word to store
    input  wire logic             in_valid,  // store request
    output logic                  in_ready,  // room left
    output logic      [WIDTH-1:0] out_data,  // oldest word
    output logic                  out_valid, // word present
    input  wire logic             out_ready  // drain accepts
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q, rd_q;
    logic [AW:0]      cnt_q;
    logic             push, pop;
    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    // storage and pointers; pointers wrap on depth
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                mem_q[wr_q] <= in_data;
                wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
            end
            if (pop)
                rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // cfg_fifo

// ****************************************************************
// test access port
// ****************************************************************
module boundary_scan_test_port
    import tap_pkg::*;
#(
    parameter logic [ID_W-1:0] ID_CODE = 32'h1234_5671  // arbitrary value
) (
    input  wire logic                 sys_clk,         // 125 MHz clock
    input  wire logic                 srst,            // sync reset
    input  wire logic                 tck,             // test clock pin
    input  wire logic                 tms,             // mode select pin
    input  wire logic                 tdi,             // serial in pin
    output logic                      tdo,             // serial out pin
    output logic                      tdo_oe,          // tdo driven
    input  wire logic [BSR_CELLS-1:0] pad_in,          // pad levels
    output logic      [BSR_CELLS-1:0] pad_out,         // pad drive value
    output logic      [BSR_CELLS-1:0] pad_oe,          // pad drive enable
    input  wire logic [BSR_CELLS-1:0] core_out,        // core drive value
    input  wire logic [BSR_CELLS-1:0] core_oe,         // core enable
    output logic      [BSR_CELLS-1:0] core_in,         // seen by core
    input  wire logic                 cfg_done,        // device configured
    input  wire logic [ID_W-1:0]      user_id_word,    // user code word
    output logic                      user_chain_one_select, // chain one
    output logic                      user_chain_two_select, // chain two
    output logic                      user_reset,      // in reset state
    output logic                      user_capture,    // capture pulse
    output logic                      user_shift,      // shift pulse
    output logic                      user_update,     // update pulse
    output logic                      user_tdi,        // bit for chains
    input  wire logic                 user_tdo_one,    // chain one out
    input  wire logic                 user_tdo_two,    // chain two out
    output logic      [CFG_W-1:0]     cfg_wr_data,     // load byte
    output logic                      cfg_wr_valid,    // load byte ready
    input  wire logic                 cfg_wr_ready,    // load accepted
    output logic                      cfg_wr_busy,     // buffer full
    input  wire logic [CFG_W-1:0]     cfg_rd_data,     // readback byte
    output logic                      cfg_rd_take,     // readback pulse
    input  wire logic                 startup_sequence_clock_source,
    output logic                      startup_step_on_test_clock
);
    logic [2:0]           tck_s;
    logic [1:0]           tms_s, tdi_s;
    logic [BSR_CELLS-1:0] pad_s1_q, pad_s2_q;
    logic                 tck_rise, tck_fall, byp_q, serial_bit, use_bsr;
    tap_state_t           state_q, state_d;
    logic [IR_W-1:0]      ir_q, ir_sh_q, op;
    logic [ID_W-1:0]      id_sh_q;
    logic [BSR_W-1:0]     bsr_sh_q, bsr_up_q;
    logic [CFG_W-1:0]     cfg_sh_q, push_data_q;
    logic [CNT_W-1:0]     cnt_q;
    logic                 fifo_ready, push_q;

    // pins are async: two flops before use; tck_s[2] only finds edges
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            tck_s    <= '0;
            tms_s    <= '1;
            tdi_s    <= '1;
            pad_s1_q <= '0;
            pad_s2_q <= '0;
        end else begin
            tck_s    <= {tck_s[1:0], tck};
            tms_s    <= {tms_s[0], tms};
            tdi_s    <= {tdi_s[0], tdi};
            pad_s1_q <= pad_in;
            pad_s2_q <= pad_s1_q;
        end
    end
    assign tck_rise = tck_s[1] && !tck_s[2];
    assign tck_fall = !tck_s[1] && tck_s[2];
    // user opcodes act as bypass until configuration installs them
    always_comb begin
        op = ir_q;
        if (!cfg_done && (ir_q == OP_USER1 || ir_q == OP_USER2 ||
                          ir_q == OP_USERID))
            op = OP_BYPASS;
    end
    // extest, sample and intest all use the one pad chain
    assign use_bsr = (op == OP_EXTEST) || (op == OP_SAMPLE) ||
                     (op == OP_INTEST);

    // controller next state under tms
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_RESET:    state_d = tms_s[1] ? ST_RESET   : ST_IDLE;
            ST_IDLE:     state_d = tms_s[1] ? ST_SEL_DR  : ST_IDLE;
            ST_SEL_DR:   state_d = tms_s[1] ? ST_SEL_IR  : ST_CAP_DR;
            ST_CAP_DR:   state_d = tms_s[1] ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: state_d = tms_s[1] ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR: state_d = tms_s[1] ? ST_UPD_DR  : ST_PAUSE_DR;
            ST_PAUSE_DR: state_d = tms_s[1] ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR: state_d = tms_s[1] ? ST_UPD_DR  : ST_SHIFT_DR;
            ST_UPD_DR:   state_d = tms_s[1] ? ST_SEL_DR  : ST_IDLE;
            ST_SEL_IR:   state_d = tms_s[1] ? ST_RESET   : ST_CAP_IR;
            ST_CAP_IR:   state_d = tms_s[1] ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: state_d = tms_s[1] ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR: state_d = tms_s[1] ? ST_UPD_IR  : ST_PAUSE_IR;
            ST_PAUSE_IR: state_d = tms_s[1] ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR: state_d = tms_s[1] ? ST_UPD_IR  : ST_SHIFT_IR;
            ST_UPD_IR:   state_d = tms_s[1] ? ST_SEL_DR  : ST_IDLE;
            default:     state_d = ST_RESET;
        endcase
    end
    // state advances only on a rising test-clock edge
    always_ff @(posedge sys_clk) begin
        if (srst)
            state_q <= ST_RESET;
        else if (tck_rise)
            state_q <= state_d;
    end
    // instruction register; loads on leaving update-ir
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ir_q    <= OP_IDCODE;
            ir_sh_q <= IR_CAPTURE;
        end else if (tck_rise) begin
            case (state_q)
                ST_RESET:    ir_q    <= OP_IDCODE;
                ST_CAP_IR:   ir_sh_q <= IR_CAPTURE;
                ST_SHIFT_IR: ir_sh_q <= {tdi_s[1], ir_sh_q[IR_W-1:1]};
                ST_UPD_IR:   ir_q    <= ir_sh_q;
                default:     ir_q    <= ir_q;
            endcase
        end
    end
    // bypass bit, plus one shifter shared by identification and user word
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            byp_q   <= 1'b0;
            id_sh_q <= '0;
        end else if (tck_rise) begin
            if (state_q == ST_CAP_DR) begin
                byp_q   <= 1'b0;
                id_sh_q <= (op == OP_USERID) ? user_id_word
                                             : ID_CODE;
            end else if (state_q == ST_SHIFT_DR) begin
                byp_q   <= tdi_s[1];
                id_sh_q <= {tdi_s[1], id_sh_q[ID_W-1:1]};
            end
        end
    end
    // pad chain captures core drive even on unused or input-only pads
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            bsr_sh_q <= '0;
            bsr_up_q <= '0;
        end else if (tck_rise && use_bsr) begin
            case (state_q)
                ST_CAP_DR: begin
                    for (int i = 0; i < BSR_CELLS; i++) begin
                        bsr_sh_q[i*CELL_W+CELL_IN]  <= pad_s2_q[i];
                        bsr_sh_q[i*CELL_W+CELL_OUT] <= core_out[i];
                        bsr_sh_q[i*CELL_W+CELL_OE]  <= core_oe[i];
                    end
                end
                ST_SHIFT_DR: bsr_sh_q <= {tdi_s[1], bsr_sh_q[BSR_W-1:1]};
                ST_UPD_DR:   bsr_up_q <= bsr_sh_q;
                default:     bsr_up_q <= bsr_up_q;
            endcase
        end
    end
    // cells stay bidirectional after configuration for interconnect tests
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pad_out <= '0;
            pad_oe  <= '0;
            core_in <= '0;
        end else begin
            for (int i = 0; i < BSR_CELLS; i++) begin
                if (op == OP_EXTEST) begin
                    pad_out[i] <= bsr_up_q[i*CELL_W+CELL_OUT];
                    pad_oe[i]  <= bsr_up_q[i*CELL_W+CELL_OE];
                end else begin
                    pad_out[i] <= core_out[i];
                    pad_oe[i]  <= core_oe[i] && (op != OP_FLOAT);
                end
                core_in[i] <= (op == OP_INTEST)
                    ? bsr_up_q[i*CELL_W+CELL_IN] : pad_s2_q[i];
            end
        end
    end

    // configuration byte shifter: lsb first, shared bit counter
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cfg_sh_q    <= '0;
            cnt_q       <= CNT_ZERO;
            push_q      <= 1'b0;
            push_data_q <= '0;
            cfg_rd_take <= 1'b0;
        end else begin
            push_q      <= 1'b0;
            cfg_rd_take <= 1'b0;
            if (tck_rise && state_q == ST_CAP_DR) begin
                cnt_q <= CNT_ZERO;
                if (op == OP_CFG_RD) begin
                    cfg_sh_q    <= cfg_rd_data;
                    cfg_rd_take <= 1'b1;
                end
            end else if (tck_rise && state_q == ST_SHIFT_DR) begin
                cnt_q <= cnt_q + 1'b1;
                if (op == OP_CFG_WR) begin
                    cfg_sh_q <= {tdi_s[1], cfg_sh_q[CFG_W-1:1]};
                    // a full buffer drops the byte; busy warns first
                    if (cnt_q == CNT_LAST && fifo_ready) begin
                        push_q      <= 1'b1;
                        push_data_q <= {tdi_s[1], cfg_sh_q[CFG_W-1:1]};
                    end
                end else if (op == OP_CFG_RD) begin
                    if (cnt_q == CNT_LAST) begin
                        cfg_sh_q    <= cfg_rd_data;
                        cfg_rd_take <= 1'b1;
                    end else
                        cfg_sh_q <= {1'b0, cfg_sh_q[CFG_W-1:1]};
                end
            end
        end
    end

    cfg_fifo #(.WIDTH(CFG_W), .DEPTH(CFG_DEPTH)) u_load_buf (
        .clk       (sys_clk),
        .rst       (srst),
        .in_data   (push_data_q),
        .in_valid  (push_q),
        .in_ready  (fifo_ready),
        .out_data  (cfg_wr_data),
        .out_valid (cfg_wr_valid),
        .out_ready (cfg_wr_ready)
    );

    // busy flag for the controller side of the load path
    always_ff @(posedge sys_clk) begin
        if (srst)
            cfg_wr_busy <= 1'b0;
        else
            cfg_wr_busy <= !fifo_ready;
    end
    // serial source of the selected path
    always_comb begin
        serial_bit = byp_q;
        if (state_q == ST_SHIFT_IR)
            serial_bit = ir_sh_q[0];
        else
            case (op)
                OP_EXTEST, OP_SAMPLE, OP_INTEST: serial_bit = bsr_sh_q[0];
                OP_USER1:  serial_bit = user_tdo_one;
                OP_USER2:  serial_bit = user_tdo_two;
                OP_CFG_RD: serial_bit = cfg_sh_q[0];
                OP_USERID, OP_IDCODE: serial_bit = id_sh_q[0];
                default:   serial_bit = byp_q;
            endcase
    end

    // tdo changes only on falling test-clock edges
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            tdo    <= 1'b0;
            tdo_oe <= 1'b0;
        end else if (tck_fall) begin
            tdo    <= serial_bit;
            tdo_oe <= (state_q == ST_SHIFT_DR) ||
                      (state_q == ST_SHIFT_IR);
        end
    end

    // user chain strobes follow controller states, one sys_clk late
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            user_chain_one_select <= 1'b0;
            user_chain_two_select <= 1'b0;
            user_reset   <= 1'b1;
            user_capture <= 1'b0;
            user_shift   <= 1'b0;
            user_update  <= 1'b0;
            user_tdi     <= 1'b0;
            startup_step_on_test_clock <= 1'b0;
        end else begin
            user_chain_one_select <= (op == OP_USER1);
            user_chain_two_select <= (op == OP_USER2);
            user_reset   <= (state_q == ST_RESET);
            user_capture <= tck_rise && (state_q == ST_CAP_DR);
            user_shift   <= tck_rise && (state_q == ST_SHIFT_DR);
            user_update  <= tck_rise && (state_q == ST_UPD_DR);
            user_tdi     <= tdi_s[1];
            startup_step_on_test_clock <= tck_rise &&
                (state_q == ST_IDLE) && (op == OP_STARTUP) &&
                startup_sequence_clock_source;
        end
    end
endmodule // boundary_scan_test_port

`default_nettype wire

//--- test/boundary_scan_test_port_assertions.sv
// pin-level assertions for the boundary-scan test port
`timescale 1ns/100ps
`default_nettype none
// ********
// checker
// ********
module scan_port_checker (
    input wire logic sys_clk,                       // system clock
    input wire logic srst,                          // sync reset
    input wire logic tck,                           // raw test clock pin
    input wire logic tdo,                           // serial out
    input wire logic tdo_oe,                        // serial out enable
    input wire logic user_reset,                    // reset level
    input wire logic user_capture,                  // capture pulse
    input wire logic user_shift,                    // shift pulse
    input wire logic user_update,                   // update pulse
    input wire logic user_chain_one_select,         // chain one
    input wire logic user_chain_two_select,         // chain two
    input wire logic cfg_wr_valid,                  // load head present
    input wire logic cfg_wr_busy,                   // load buffer full
    input wire logic startup_sequence_clock_source, // step source
    input wire logic startup_step_on_test_clock     // step pulse
);
    // all checks run on sys_clk
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    a_reset_quiets_port: assert property (disable iff (1'b0)
        srst |=> user_reset && !tdo_oe && !user_shift)
        else $error("port not quiet after reset");
    // tck low phase spans about eight cycles, so a move must sit inside it
    a_tdo_moves_after_fall: assert property (
        $changed(tdo) |-> !tck && !$past(tck, 2))
        else $error("tdo moved outside tck low");
    a_shift_drives_tdo: assert property (
        user_shift |-> tdo_oe)
        else $error("shift without tdo enabled");
    a_strobes_exclusive: assert property (
        $onehot0({user_reset, user_capture, user_shift, user_update}))
        else $error("user strobes overlap");
    a_shift_single_pulse: assert property (
        user_shift |=> !user_shift [*4])
        else $error("shift strobe longer than one cycle");
    a_chains_exclusive: assert property (
        !(user_chain_one_select && user_chain_two_select))
        else $error("both user chains selected");
    a_full_means_valid: assert property (
        cfg_wr_busy |-> cfg_wr_valid)
        else $error("load buffer full but empty head");
    a_step_needs_source: assert property (
        startup_step_on_test_clock |-> startup_sequence_clock_source
            && !user_shift && !user_capture)
        else $error("step without tck source");
endmodule // scan_port_checker

bind boundary_scan_test_port scan_port_checker u_scan_port_checker (
    .sys_clk, .srst, .tck, .tdo, .tdo_oe, .user_reset, .user_capture,
    .user_shift, .user_update, .user_chain_one_select,
    .user_chain_two_select, .cfg_wr_valid, .cfg_wr_busy,
    .startup_sequence_clock_source, .startup_step_on_test_clock);
`default_nettype wire

//--- test/scan_controller.sv
// far-side test controller model that drives the scan pins
`timescale 1ns/100ps
`default_nettype none
// ********
// test controller
// ********
module scan_controller (
    output logic      tck, // test clock, parked low between frames
    output logic      tms, // mode select
    output logic      tdi, // serial data to the port
    input  wire logic tdo  // serial data back, z while undriven
);
    // pins rest at their pull-up level, clock stands still
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end

    // one 125 ns bit, pins set a quarter period early, tdo taken at rise
    task automatic clock_bit(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #31.25 tck = 1'b1;
        q = tdo;
        #62.5 tck = 1'b0;
        #31.25;
    endtask

    // five ones reach test-logic-reset from any state, then idle
    task automatic goto_idle();
        logic q;
        repeat (5) clock_bit(1'b1, 1'b1, q);
        clock_bit(1'b0, 1'b1, q);
    endtask

    // ir or dr scan from idle to idle, lsb first, n in 1..64
    task automatic scan(input logic ir, input int n, input logic [63:0] din,
                        output logic [63:0] dout);
        logic q;
        dout = '0;
        clock_bit(1'b1, 1'b1, q);
        if (ir)
            clock_bit(1'b1, 1'b1, q);
        clock_bit(1'b0, 1'b1, q); // capture
        clock_bit(1'b0, 1'b1, q); // into shift
        for (int i = 0; i < n; i++) begin
            clock_bit(i == n - 1, din[i], q);
            dout[i] = q;
        end
        clock_bit(1'b1, 1'b1, q); // update
        clock_bit(1'b0, 1'b1, q); // back to idle, tdi left at pull-up
    endtask
endmodule // scan_controller
`default_nettype wire

//--- test/boundary_scan_test_port_test.sv
// self-checking bench for the boundary-scan test port
`timescale 1ns/100ps
`default_nettype none
module boundary_scan_test_port_test
    import tap_pkg::*;
;
    localparam logic [ID_W-1:0] TEST_ID = 32'hA5C3_0F01; // arbitrary value
    logic                 sys_clk, srst, tck, tms, tdi, tdo, tdo_oe, cfg_done;
    logic                 user_reset, user_capture, user_shift, user_update;
    logic                 user_tdi, user_tdo_one, user_tdo_two;
    logic                 user_chain_one_select, user_chain_two_select;
    logic                 cfg_wr_valid, cfg_wr_ready, cfg_wr_busy, cfg_rd_take;
    logic                 startup_sequence_clock_source;
    logic                 startup_step_on_test_clock;
    logic [BSR_CELLS-1:0] pad_in, pad_out, pad_oe, core_out, core_oe, core_in;
    logic [ID_W-1:0]      user_id_word;
    logic [CFG_W-1:0]     cfg_wr_data, cfg_rd_data;
    wire                  tdo_line;
    int                   errors, n_compared, n_cap, n_shift, n_upd, n_step;

    // no keeper on the serial output, so an idle line floats
    assign tdo_line = tdo_oe ? tdo : 1'bz;

    boundary_scan_test_port #(.ID_CODE(TEST_ID)) u_boundary_scan_test_port (
        .sys_clk, .srst, .tck, .tms, .tdi, .tdo, .tdo_oe, .pad_in, .pad_out,
        .pad_oe, .core_out, .core_oe, .core_in, .cfg_done, .user_id_word,
        .user_chain_one_select, .user_chain_two_select, .user_reset,
        .user_capture, .user_shift, .user_update, .user_tdi, .user_tdo_one,
        .user_tdo_two, .cfg_wr_data, .cfg_wr_valid, .cfg_wr_ready,
        .cfg_wr_busy, .cfg_rd_data, .cfg_rd_take,
        .startup_sequence_clock_source, .startup_step_on_test_clock);
    scan_controller u_scan_controller (.tck, .tms, .tdi, .tdo(tdo_line));

    // ********
    // clock, pulse counters, helpers
    // ********
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // counting pulses rather than probing them avoids sampling races
    always @(posedge sys_clk) begin
        n_cap += int'(user_capture === 1'b1);
        n_shift += int'(user_shift === 1'b1);
        n_upd += int'(user_update === 1'b1);
        n_step += int'(startup_step_on_test_clock === 1'b1);
    end

    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic check(input logic [63:0] seen, exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t %s: %h not %h", $time, what, seen, exp);
        end
    endtask

    task automatic set_op(input logic [IR_W-1:0] op);
        logic [63:0] got;
        u_scan_controller.scan(1'b1, IR_W, 64'(op), got);
        step(1);
        check(got[IR_W-1:0], IR_CAPTURE, "ir capture");
    endtask

    task automatic dr(input int n, input logic [63:0] din,
                      output logic [63:0] q);
        u_scan_controller.scan(1'b0, n, din, q);
        step(1);
    endtask

    task automatic wrap_up();
        if (errors == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ********
    // scenarios
    // ********
    task automatic test_idcode();
        logic [63:0] got;
        check(user_reset, 1'b1, "reset level");
        u_scan_controller.goto_idle();
        dr(ID_W, 64'h0, got);
        check(got[ID_W-1:0], TEST_ID, "id code");
    endtask

    // bypass, reserved, float and unconfigured user codes
    task automatic test_bypass_family();
        logic [IR_W-1:0] ops [5] = '{OP_BYPASS, 5'h06, OP_FLOAT, OP_USER1,
                                     OP_USERID};
        logic [63:0]     got;
        foreach (ops[i]) begin
            set_op(ops[i]);
            if (ops[i] == OP_FLOAT)
                check(pad_oe, 8'h00, "outputs floated");
            dr(8, 64'h96, got);
            check(got[7:0], 8'h2C, "one-bit bypass");
        end
    endtask

    task automatic test_sample_extest();
        logic [63:0] got;
        logic [63:0] pat = 64'hA5_3C96;
        pad_in = 8'h5A;
        set_op(OP_SAMPLE);
        dr(BSR_W, pat, got);
        for (int i = 0; i < BSR_CELLS; i++)
            check(got[CELL_W*i+CELL_IN], pad_in[i], "sampled pad");
        cfg_done = 1'b1; // configuration ends between scans
        set_op(OP_EXTEST);
        pad_in = 8'hA5;
        step(4);
        for (int i = 0; i < BSR_CELLS; i++) begin
            check(pad_out[i], pat[CELL_W*i+CELL_OUT], "drive");
            check(pad_oe[i], pat[CELL_W*i+CELL_OE], "enable");
        end
        dr(BSR_W, pat, got);
        for (int i = 0; i < BSR_CELLS; i++)
            check(got[CELL_W*i+CELL_IN], pad_in[i], "extest capture");
        set_op(OP_INTEST);
        for (int i = 0; i < BSR_CELLS; i++)
            check(core_in[i], pat[CELL_W*i+CELL_IN], "intest");
    endtask

    task automatic test_user_chains();
        logic [63:0] got;
        user_id_word = 32'h3C5A_96E1;
        set_op(OP_USER1);
        check(user_chain_one_select, 1'b1, "chain one select");
        n_cap = 0;
        n_shift = 0;
        n_upd = 0;
        dr(8, 64'h5A, got);
        check(got[7:0], 8'hFF, "chain one data");
        check(64'(n_cap), 64'd1, "capture strobes");
        check(64'(n_shift), 64'd8, "shift strobes");
        check(64'(n_upd), 64'd1, "update strobes");
        set_op(OP_USER2);
        check(user_chain_two_select, 1'b1, "chain two select");
        dr(8, 64'h5A, got);
        check(got[7:0], 8'h00, "chain two data");
        set_op(OP_USERID);
        dr(ID_W, 64'h0, got);
        check(got[ID_W-1:0], user_id_word, "user word");
    endtask

    task automatic test_startup_and_readback();
        logic        q;
        logic [63:0] got;
        startup_sequence_clock_source = 1'b1;
        set_op(OP_STARTUP);
        n_step = 0;
        repeat (3) u_scan_controller.clock_bit(1'b0, 1'b1, q);
        step(1);
        check(64'(n_step), 64'd3, "steps on test clock");
        startup_sequence_clock_source = 1'b0;
        n_step = 0;
        repeat (3) u_scan_controller.clock_bit(1'b0, 1'b1, q);
        step(1);
        check(64'(n_step), 64'd0, "no steps on other source");
        cfg_rd_data = 8'hA5;
        set_op(OP_CFG_RD);
        dr(8, 64'h0, got);
        check(got[7:0], 8'hA5, "readback byte");
    endtask

    // fill the load buffer with the drain stalled, overflow it, drain it
    task automatic test_cfg_load();
        logic [63:0] got;
        set_op(OP_CFG_WR);
        dr(64, 64'h8877_6655_4433_2211, got);
        check(cfg_wr_busy, 1'b1, "load buffer full");
        dr(8, 64'hEE, got);
        for (int i = 0; i < CFG_DEPTH; i++) begin
            check(cfg_wr_valid, 1'b1, "load byte present");
            check(cfg_wr_data, 8'(8'h11 * (i + 1)), "load byte order");
            cfg_wr_ready = 1'b1;
            step(1);
            cfg_wr_ready = 1'b0;
            step(1);
        end
        check(cfg_wr_valid, 1'b0, "load buffer drained");
    endtask

    // ********
    // main sequence and watchdog
    // ********
    initial begin
        srst = 1'b1;
        pad_in = 8'h00;
        core_out = 8'hC3;
        core_oe = 8'hF0;
        cfg_done = 1'b0;
        user_id_word = 32'h0000_0000;
        user_tdo_one = 1'b1;
        user_tdo_two = 1'b0;
        cfg_wr_ready = 1'b0;
        cfg_rd_data = 8'h00;
        startup_sequence_clock_source = 1'b0;
        errors = 0;
        n_compared = 0;
        step(5);
        srst = 1'b0;
        step(3);
        test_idcode();
        test_bypass_family();
        test_sample_extest();
        test_user_chains();
        test_startup_and_readback();
        test_cfg_load();
        wrap_up();
    end

    // ~480 bits of 125 ns planned; allow over six times that
    initial begin
        #400000;
        errors++;
        wrap_up();
    end
endmodule // boundary_scan_test_port_test
`default_nettype wire
